// file: design/ftc_params.svh
// Operation
// - flash fetch stretches core cycle 1..4
// - flash speed is slower of both settings
// - leaving flash restores earlier core divisor for one core cycle
// - table read takes 1..4 core cycles
// - write time base divides core clock
// - divisor codes map 2..128, upper reserved
`ifndef FTC_PARAMS_SVH
`define FTC_PARAMS_SVH
// register indices on the plain port
`define FTC_ADDR_W      4
`define FTC_CFG_ADDR    4'h0
`define FTC_STAT_ADDR   4'h1
// config fields
`define FTC_WAIT_MSB    7
`define FTC_WAIT_LSB    6
`define FTC_RDC_MSB     5
`define FTC_RDC_LSB     4
`define FTC_WDIV_MSB    3
`define FTC_WDIV_LSB    0
// slowest, safest setting until software tunes it
`define FTC_CFG_RST     8'hfc
// last non-reserved divisor code
`define FTC_WDIV_MAXOK  4'hc
// status bit positions
`define FTC_ST_FLASH    7
`define FTC_ST_RDBUSY   6
`define FTC_ST_RSVD     5
`endif

// file: design/ftc_pkg.sv
package ftc_pkg;
  // configuration register layout
  typedef struct packed {
    logic [1:0] flash_exec_wait_sel;
    logic [1:0] flash_read_cycles_sel;
    logic [3:0] flash_write_divisor_sel;
  } ftc_cfg_s;
  // table read sequencer
  typedef enum logic [0:0] {
    FTC_RD_IDLE = 1'b0,
    FTC_RD_BUSY = 1'b1
  } ftc_rd_e;
  typedef logic [8:0] ftc_wdiv_t;
endpackage

// file: design/ftc_timing.sv
// The plain strobed port and the address map are this design's own decisions.
`include "ftc_params.svh"
module ftc_timing (
  // clock and reset
  input  wire logic                   ref_clk_in,
  input  wire logic                   sys_rst_in,
  // register port
  input  wire logic [`FTC_ADDR_W-1:0] reg_addr_in,
  input  wire logic [7:0]             reg_wdata_in,
  input  wire logic                   reg_wr_in,
  input  wire logic                   reg_rd_in,
  output logic      [7:0]             reg_rdata_out,
  // core side
  input  wire logic                   exec_from_flash_in,
  input  wire logic [3:0]             core_speed_divisor_in,
  input  wire logic                   tbl_read_req_in,
  // timing outputs
  output logic                        core_clk_en_out,
  output logic                        tbl_read_busy_out,
  output logic                        tbl_read_done_out,
  output logic                        flash_wr_tick_out
);
  // config register and next value
  ftc_pkg::ftc_cfg_s flash_timing_config_ff, nxt_flash_timing_config;
  logic [7:0]        rdata_ff, nxt_rdata;       // read data, one cycle late
  // core clock divider state
  logic [3:0]        core_cnt_ff, nxt_core_cnt;
  logic [3:0]        eff_div_ff, nxt_eff_div;   // system cycles per core cycle
  logic [3:0]        saved_div_ff, nxt_saved_div;
  logic              in_flash_ff, nxt_in_flash;
  // table read state
  ftc_pkg::ftc_rd_e  rd_state_ff, nxt_rd_state;
  logic [1:0]        rd_cnt_ff, nxt_rd_cnt;
  logic              rd_done_ff, nxt_rd_done;
  // write time base state
  ftc_pkg::ftc_wdiv_t wcnt_ff, nxt_wcnt;
  logic              wtick_ff, nxt_wtick;
  // combinational helpers
  logic              core_en;
  logic [3:0]        ram_div, wait_div, flash_div;
  ftc_pkg::ftc_wdiv_t wdiv;
  logic              wdiv_rsvd;

  // divisor zero would wrap to a 16-cycle core period, so treat it as one
  always_comb
  begin
    ram_div   = (core_speed_divisor_in == 4'h0) ? 4'h1 : core_speed_divisor_in;
    wait_div  = {2'h0, flash_timing_config_ff.flash_exec_wait_sel} + 4'h1;
    flash_div = (wait_div > ram_div) ? wait_div : ram_div;
    core_en   = (core_cnt_ff >= eff_div_ff - 4'h1);
  end

  // write divisor lookup; reserved codes still divide as encoded
  always_comb
  begin
    wdiv_rsvd = (flash_timing_config_ff.flash_write_divisor_sel > `FTC_WDIV_MAXOK);
    case (flash_timing_config_ff.flash_write_divisor_sel)
      4'h0:    wdiv = 9'h002;
      4'h1:    wdiv = 9'h003;
      4'h2:    wdiv = 9'h004;
      4'h3:    wdiv = 9'h006;
      4'h4:    wdiv = 9'h008;
      4'h5:    wdiv = 9'h00c;
      4'h6:    wdiv = 9'h010;
      4'h7:    wdiv = 9'h018;
      4'h8:    wdiv = 9'h020;
      4'h9:    wdiv = 9'h030;
      4'ha:    wdiv = 9'h040;
      4'hb:    wdiv = 9'h060;
      4'hc:    wdiv = 9'h080;
      4'hd:    wdiv = 9'h0c0;
      4'he:    wdiv = 9'h100;
      default: wdiv = 9'h180;
    endcase
  end

  // register port next values
  always_comb
  begin
    nxt_flash_timing_config = flash_timing_config_ff;
    nxt_rdata               = 8'h00;
    if (reg_wr_in && reg_addr_in == `FTC_CFG_ADDR)
    begin
      nxt_flash_timing_config = reg_wdata_in;
    end
    if (reg_rd_in)
    begin
      case (reg_addr_in)
        `FTC_CFG_ADDR:  nxt_rdata = flash_timing_config_ff;
        `FTC_STAT_ADDR: nxt_rdata = {in_flash_ff, rd_state_ff == ftc_pkg::FTC_RD_BUSY, wdiv_rsvd,
                                     1'b0, eff_div_ff};
        default:        nxt_rdata = 8'h00; // unmapped reads as zero
      endcase
    end
  end

  // core clock divider; divisor only changes at a core cycle boundary
  always_comb
  begin
    nxt_core_cnt  = core_en ? 4'h0 : core_cnt_ff + 4'h1;
    nxt_eff_div   = eff_div_ff;
    nxt_saved_div = saved_div_ff;
    nxt_in_flash  = in_flash_ff;
    if (core_en)
    begin
      nxt_in_flash = exec_from_flash_in;
      if (exec_from_flash_in)
      begin
        nxt_eff_div = flash_div;
        if (!in_flash_ff)
        begin
          nxt_saved_div = eff_div_ff; // remember divisor on entry
        end
      end
      else if (in_flash_ff)
      begin
        nxt_eff_div = saved_div_ff;
      end
      else
      begin
        nxt_eff_div = ram_div;
      end
    end
  end

  // table read: counts core cycles set by the read code
  always_comb
  begin
    nxt_rd_state = rd_state_ff;
    nxt_rd_cnt   = rd_cnt_ff;
    nxt_rd_done  = 1'b0;
    case (rd_state_ff)
      ftc_pkg::FTC_RD_IDLE:
      begin
        if (tbl_read_req_in)
        begin
          nxt_rd_state = ftc_pkg::FTC_RD_BUSY;
          nxt_rd_cnt   = 2'h0;
        end
      end
      ftc_pkg::FTC_RD_BUSY:
      begin
        if (core_en)
        begin
          if (rd_cnt_ff == flash_timing_config_ff.flash_read_cycles_sel)
          begin
            nxt_rd_state = ftc_pkg::FTC_RD_IDLE;
            nxt_rd_done  = 1'b1;
          end
          else
          begin
            nxt_rd_cnt = rd_cnt_ff + 2'h1;
          end
        end
      end
      default: nxt_rd_state = ftc_pkg::FTC_RD_IDLE;
    endcase
  end

  // erase/write time base, one tick per wdiv core cycles
  always_comb
  begin
    nxt_wcnt  = wcnt_ff;
    nxt_wtick = 1'b0;
    if (core_en)
    begin
      if (wcnt_ff >= wdiv - 9'h001)
      begin
        nxt_wcnt  = 9'h000;
        nxt_wtick = 1'b1;
      end
      else
      begin
        nxt_wcnt = wcnt_ff + 9'h001;
      end
    end
  end

  // all state registers except the checking helper
  always_ff @(posedge ref_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      flash_timing_config_ff <= `FTC_CFG_RST;
      rdata_ff               <= 8'h00;
      core_cnt_ff            <= 4'h0;
      eff_div_ff             <= 4'h1;
      saved_div_ff           <= 4'h1;
      in_flash_ff            <= 1'b0;
      rd_state_ff            <= ftc_pkg::FTC_RD_IDLE;
      rd_cnt_ff              <= 2'h0;
      rd_done_ff             <= 1'b0;
      wcnt_ff                <= 9'h000;
      wtick_ff               <= 1'b0;
    end
    else
    begin
      flash_timing_config_ff <= nxt_flash_timing_config;
      rdata_ff               <= nxt_rdata;
      core_cnt_ff            <= nxt_core_cnt;
      eff_div_ff             <= nxt_eff_div;
      saved_div_ff           <= nxt_saved_div;
      in_flash_ff            <= nxt_in_flash;
      rd_state_ff            <= nxt_rd_state;
      rd_cnt_ff              <= nxt_rd_cnt;
      rd_done_ff             <= nxt_rd_done;
      wcnt_ff                <= nxt_wcnt;
      wtick_ff               <= nxt_wtick;
    end
  end

  // outputs
  assign reg_rdata_out     = rdata_ff;
  assign core_clk_en_out   = core_en;
  assign tbl_read_busy_out = (rd_state_ff == ftc_pkg::FTC_RD_BUSY);
  assign tbl_read_done_out = rd_done_ff;
  assign flash_wr_tick_out = wtick_ff;

  // checking helper: core enables seen during a table read
  logic [2:0] chk_rd_ff, nxt_chk_rd;
  // idle clears the count, so each read starts from zero
  always_comb
  begin
    nxt_chk_rd = chk_rd_ff;
    if (rd_state_ff == ftc_pkg::FTC_RD_IDLE)
    begin
      nxt_chk_rd = 3'h0;
    end
    else if (core_en)
    begin
      nxt_chk_rd = chk_rd_ff + 3'h1;
    end
  end
  // helper register only
  always_ff @(posedge ref_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      chk_rd_ff <= 3'h0;
    end
    else
    begin
      chk_rd_ff <= nxt_chk_rd;
    end
  end

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (sys_rst_in);

  // two-cycle core period once divisor settles at two
  sequence two_div_s;
    core_en ##1 (eff_div_ff == 4'h2);
  endsequence
  sequence two_gap_s;
    !core_en ##1 core_en;
  endsequence

  cfg_fields_a: assert property (reg_wr_in && reg_addr_in == `FTC_CFG_ADDR |=>
    flash_timing_config_ff.flash_exec_wait_sel == $past(reg_wdata_in[7:6]) &&
    flash_timing_config_ff.flash_read_cycles_sel == $past(reg_wdata_in[5:4]) &&
    flash_timing_config_ff.flash_write_divisor_sel == $past(reg_wdata_in[3:0]))
    else $error("config fields not stored in place");
  flash_stretch_a: assert property (two_div_s |-> two_gap_s)
    else $error("core period does not match divisor");
  slower_speed_a: assert property (core_en && exec_from_flash_in |=>
    eff_div_ff >= $past(ram_div) && eff_div_ff >= $past(wait_div))
    else $error("flash speed faster than a setting");
  restore_div_a: assert property (core_en && in_flash_ff && !exec_from_flash_in |=>
    eff_div_ff == $past(saved_div_ff))
    else $error("divisor not restored on leaving flash");
  read_cycles_a: assert property (tbl_read_done_out |->
    chk_rd_ff == {1'b0, flash_timing_config_ff.flash_read_cycles_sel} + 3'h1)
    else $error("table read length wrong");
  wr_tick_a: assert property (core_en && wcnt_ff == wdiv - 9'h001 |=> flash_wr_tick_out)
    else $error("write time base tick missing");
  rsvd_code_a: assert property (reg_rd_in && reg_addr_in == `FTC_STAT_ADDR &&
    flash_timing_config_ff.flash_write_divisor_sel > `FTC_WDIV_MAXOK |=> reg_rdata_out[`FTC_ST_RSVD])
    else $error("reserved divisor not flagged");
  unmapped_rd_a: assert property (reg_rd_in && reg_addr_in > `FTC_STAT_ADDR |=> reg_rdata_out == 8'h00)
    else $error("unmapped read not zero");
endmodule

// file: dv/ftc_timing_tb.sv
module ftc_timing_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // one row: config byte, core state, expected core period in system cycles
  typedef struct packed {
    logic [7:0] cfg;
    logic       fl;
    logic [3:0] spd;
    logic [8:0] per;
  } ftc_tb_row_s;
  logic       ref_clk_in;            // system clock
  logic       sys_rst_in;            // async reset
  logic [3:0] reg_addr_in;           // register index
  logic [7:0] reg_wdata_in;          // write data
  logic       reg_wr_in;             // write strobe
  logic       reg_rd_in;             // read strobe
  logic [7:0] reg_rdata_out;         // read data
  logic       exec_from_flash_in;    // core fetching from flash
  logic [3:0] core_speed_divisor_in; // speed register value
  logic       tbl_read_req_in;       // table read request
  logic       core_clk_en_out;       // core cycle pulse
  logic       tbl_read_busy_out;     // table read running
  logic       tbl_read_done_out;     // table read finished
  logic       flash_wr_tick_out;     // write time base tick
  int         failures = 0;          // mismatches seen
  int         checks = 0;            // comparisons made
  bit         tk_sel;                // which pulse gap() times
  logic [7:0] d;                     // read-back scratch
  logic [8:0] n;                     // measured period
  int         cnt;                   // core pulses during a table read
  int unsigned dv[13] = '{2, 3, 4, 6, 8, 12, 16, 24, 32, 48, 64, 96, 128};
  // flash rows stretch to the slower of wait code and speed; ram rows follow speed
  ftc_tb_row_s rows[7] = '{'{8'h00, 1'b1, 4'h1, 9'h001}, '{8'h40, 1'b1, 4'h1, 9'h002},
                           '{8'h80, 1'b1, 4'h1, 9'h003}, '{8'hc0, 1'b1, 4'h2, 9'h004},
                           '{8'hc0, 1'b1, 4'h6, 9'h006}, '{8'hc0, 1'b0, 4'h2, 9'h002},
                           '{8'h00, 1'b0, 4'h0, 9'h001}};

  ftc_timing DUT (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .exec_from_flash_in(exec_from_flash_in),
    .core_speed_divisor_in(core_speed_divisor_in), .tbl_read_req_in(tbl_read_req_in),
    .core_clk_en_out(core_clk_en_out), .tbl_read_busy_out(tbl_read_busy_out),
    .tbl_read_done_out(tbl_read_done_out), .flash_wr_tick_out(flash_wr_tick_out));

  // free-running system clock
  always #5 ref_clk_in = ~ref_clk_in;

  // verdict and end of run
  task automatic results();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD at %0t: got %0h want %0h", $time, got, exp);
    end
  endtask

  // one-cycle write strobe
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge ref_clk_in);
    reg_addr_in  <= a;
    reg_wdata_in <= v;
    reg_wr_in    <= 1'b1;
    @(posedge ref_clk_in);
    reg_wr_in    <= 1'b0;
  endtask

  // data stands only in the cycle after the strobe, so sample mid-cycle there
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge ref_clk_in);
    reg_addr_in <= a;
    reg_rd_in   <= 1'b1;
    @(posedge ref_clk_in);
    reg_rd_in   <= 1'b0;
    @(negedge ref_clk_in);
    v = reg_rdata_out;
  endtask

  // cycles between two pulses; a pulse that never comes ends the run
  task automatic gap(input bit t, output logic [8:0] p);
    int i;
    tk_sel = t;
    p = 9'h000;
    for (i = 0; i < 600 && ((tk_sel ? flash_wr_tick_out : core_clk_en_out) !== 1'b1); i++)
      @(negedge ref_clk_in);
    do
    begin
      @(negedge ref_clk_in);
      p++;
    end while ((tk_sel ? flash_wr_tick_out : core_clk_en_out) !== 1'b1 && p < 9'h1f0);
    if (i >= 600 || p >= 9'h1f0)
    begin
      failures++;
      $display("BAD at %0t: pulse timeout", $time);
      results();
    end
  endtask

  initial
  begin
    ref_clk_in = 1'b0;
    sys_rst_in = 1'b1;
    reg_addr_in = 4'h0;
    reg_wdata_in = 8'h00;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    exec_from_flash_in = 1'b0;
    core_speed_divisor_in = 4'h1;
    tbl_read_req_in = 1'b0;
    repeat (6) @(posedge ref_clk_in);
    sys_rst_in <= 1'b0;
    rd(4'h0, d);
    chk({1'b0, d}, 9'h0fc);
    rd(4'h5, d);
    chk({1'b0, d}, 9'h000);
    wr(4'h1, 8'h00);
    rd(4'h0, d);
    chk({1'b0, d}, 9'h0fc);
    $display("reset and map test done");
    foreach (rows[i])
    begin
      wr(4'h0, rows[i].cfg);
      exec_from_flash_in <= rows[i].fl;
      core_speed_divisor_in <= rows[i].spd;
      // third gap: the first ram cycle after flash still runs the saved divisor
      repeat (3) gap(1'b0, n);
      chk(n, rows[i].per);
      rd(4'h0, d);
      chk({1'b0, d}, {1'b0, rows[i].cfg});
    end
    $display("core stretch test done");
    // each tick spans the divisor in core cycles; speed 0, treated as one, makes core cycles system cycles
    for (int c = 0; c < 13; c++)
    begin
      wr(4'h0, {4'h0, c[3:0]});
      gap(1'b1, n);
      gap(1'b1, n);
      chk(n, dv[c][8:0]);
    end
    wr(4'h0, 8'h0d);
    rd(4'h1, d);
    chk({8'h00, d[5]}, 9'h001);
    // a 100 MHz part: slowest wait and read codes, divisor 128 gives a 1.28 us base
    wr(4'h0, 8'hfc);
    repeat (2) gap(1'b1, n);      // speed input left alone while ticks are timed
    chk(n, 9'h080);
    $display("write divisor test done");
    @(posedge ref_clk_in);
    core_speed_divisor_in <= 4'h2;
    for (int c = 0; c < 4; c++)
    begin
      wr(4'h0, {2'b00, c[1:0], 4'h0});
      tbl_read_req_in <= 1'b1;
      @(posedge ref_clk_in);
      tbl_read_req_in <= 1'b0;
      cnt = 0;
      for (int i = 0; i < 60 && tbl_read_done_out !== 1'b1; i++)
      begin
        @(negedge ref_clk_in);
        if (core_clk_en_out === 1'b1 && tbl_read_busy_out === 1'b1)
          cnt++;
      end
      // a read that never ends is a mismatch and stops the run
      if (tbl_read_done_out !== 1'b1)
      begin
        chk(9'h1ff, 9'h000);
        results();
      end
      chk(cnt[8:0], c[8:0] + 9'h001);
    end
    $display("table read test done");
    // ram at speed 3, enter flash under wait code 3, drop speed to 2 inside, then leave
    wr(4'h0, 8'hc0);
    core_speed_divisor_in <= 4'h3;
    repeat (3) gap(1'b0, n);
    chk(n, 9'h003);
    @(posedge ref_clk_in);
    exec_from_flash_in <= 1'b1;
    repeat (3) gap(1'b0, n);
    chk(n, 9'h004);
    @(posedge ref_clk_in);
    core_speed_divisor_in <= 4'h2;
    repeat (3) gap(1'b0, n);
    chk(n, 9'h004);
    // leave right after a pulse: the next core cycle is the last in flash
    @(posedge ref_clk_in);
    exec_from_flash_in <= 1'b0;
    @(negedge ref_clk_in);
    gap(1'b0, n);
    chk(n, 9'h003);
    gap(1'b0, n);
    chk(n, 9'h002);
    $display("flash exit test done");
    // reset in mid-run: outputs idle, core enable high, config back to its reset byte
    @(posedge ref_clk_in);
    sys_rst_in <= 1'b1;
    @(negedge ref_clk_in);
    chk({1'b0, reg_rdata_out}, 9'h000);
    chk({5'h00, core_clk_en_out, tbl_read_busy_out, tbl_read_done_out, flash_wr_tick_out}, 9'h008);
    repeat (2) @(posedge ref_clk_in);
    sys_rst_in <= 1'b0;
    rd(4'h0, d);
    chk({1'b0, d}, 9'h0fc);
    $display("mid-run reset test done");
    results();
  end
endmodule
